// ### rtl/fsw_link.sv
`timescale 1ns/1ns
`default_nettype none
module fsw_link #(
   parameter logic [7:0] RDSR_OP = 8'h05
) (
   // link pins
   input wire logic sck_i,
   input wire logic ce_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   // core side
   input wire logic reset_n_i,
   input wire logic [7:0] status_i,
   output fsw_pkg::fsw_cmd_type cmd_o
);

   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [6:0] shift;
   } fsw_frame_type;

   typedef struct packed {
      logic oe;
      logic bit_out;
   } fsw_so_type;

   fsw_frame_type f_reg;
   fsw_frame_type f_next;
   fsw_pkg::fsw_cmd_type c_reg;
   fsw_pkg::fsw_cmd_type c_next;
   fsw_so_type s_reg;
   logic [7:0] stat_s;
   logic [7:0] word;

   // per-bit level sync; a byte may mix old and new bits for one edge
   fsw_sync2 #(.W(8)) u_stat_sync (
      .clk_i(sck_i),
      .reset_n_i(reset_n_i),
      .d_i(status_i),
      .q_o(stat_s)
   );

   always_comb begin
      f_next = f_reg;
      c_next = c_reg;
      word = {f_reg.shift, si_i};
      f_next.shift = word[6:0];
      f_next.bit_cnt = f_reg.bit_cnt + 3'h1;
      if (f_reg.bit_cnt == 3'h0 && f_reg.byte_cnt == 2'h0) begin
         c_next.frame_tgl = ~c_reg.frame_tgl;
         c_next.got_op = 1'b0;
         c_next.got_data = 1'b0;
      end
      if (f_reg.bit_cnt == 3'h7) begin
         if (f_reg.byte_cnt != 2'h2) begin
            f_next.byte_cnt = f_reg.byte_cnt + 2'h1;
         end
         if (f_reg.byte_cnt == 2'h0) begin
            c_next.opcode = word;
            c_next.got_op = 1'b1;
         end else if (f_reg.byte_cnt == 2'h1) begin
            c_next.data = word;
            c_next.got_data = 1'b1;
         end
      end
   end

   // frame counters end with the frame itself; sck may stop any time
   always_ff @(posedge sck_i or posedge ce_n_i) begin
      if (ce_n_i) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   // captured command outlives the frame for the core to pick up
   always_ff @(posedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   // status byte repeats every eight clocks until ce_n rises, each pass read from the live synced copy
   always_ff @(negedge sck_i or posedge ce_n_i) begin
      if (ce_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg.oe <= (f_reg.byte_cnt != 2'h0) && c_reg.got_op &&
                     (c_reg.opcode == RDSR_OP);
         s_reg.bit_out <= stat_s[3'h7 - f_reg.bit_cnt];
      end
   end

   assign cmd_o = c_reg;
   assign so_o = s_reg.bit_out;
   assign so_oe_o = s_reg.oe;

endmodule
`default_nettype wire

// ### rtl/fsw_pkg.sv
package fsw_pkg;

   // ---------------------------------------------------------------
   // status register layout
   // ---------------------------------------------------------------
   localparam int STAT_W = 8;
   localparam int BUSY_BIT = 0;
   localparam int WEL_BIT = 1;
   localparam int BP_LSB = 2;
   localparam int BP_W = 4;
   localparam int QE_BIT = 6;
   localparam int STATUS_WRITE_DISABLE_BIT = 7;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [3:0] NV_BP_RESET = 4'h0;
   localparam logic NV_QE_RESET = 1'b0;
   localparam logic NV_STATUS_WRITE_DISABLE_RESET = 1'b0;

   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE_INSTR = 8'h06;
   localparam logic [7:0] OP_WRITE_STATUS_INSTR = 8'h01;
   localparam logic [7:0] OP_CER_A = 8'hC7;
   localparam logic [7:0] OP_CER_B = 8'h60;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_SET_READ_PARAMS_VOLATILE_VOL = 8'hC0;
   localparam logic [7:0] OP_WRBR_VOL = 8'h17;

   // latch-gated opcodes; program and erase come first
   localparam int N_PE = 15;
   localparam int N_GATED = 39;
   localparam logic [7:0] GATED_OPS [0:38] = '{
      8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E,
      8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60,
      8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h15, 8'h18, 8'hC5,
      8'h64, 8'h62, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6,
      8'h91, 8'h7E, 8'h98, 8'hE8, 8'h43, 8'h4A
   };

   // ---------------------------------------------------------------
   // protection map and timing
   // ---------------------------------------------------------------
   localparam int BLK_W = 9;
   localparam logic [9:0] NUM_BLOCKS = 10'd512;
   localparam logic [9:0] PROT_COUNT [0:15] = '{
      10'd0, 10'd1, 10'd2, 10'd4, 10'd8, 10'd16, 10'd32, 10'd64,
      10'd128, 10'd256, 10'd384, 10'd448, 10'd480, 10'd496, 10'd504,
      10'd512
   };
   localparam int OP_CYCLES_DEF = 64;
   localparam int TIMER_W = 16;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FSW_IDLE = 3'b001,
      FSW_BUSY = 3'b010,
      FSW_SUSP = 3'b100
   } fsw_state_type;

   typedef struct packed {
      logic frame_tgl;
      logic got_op;
      logic got_data;
      logic [7:0] opcode;
      logic [7:0] data;
   } fsw_cmd_type;

endpackage

// ### rtl/fsw_status_core.sv
// Functional notes
// - eight-bit status: busy, latch, protect, quad, lock
// - busy is read-only, high during operations
// - while busy, drop all but reads, resets
// - suspend also accepted during program or erase
// - busy clears at operation end, always
// - latch low blocks gated writes; high allows
// - write-enable opcode sets the latch
// - write-disable opcode clears the latch
// - latch clears when a gated operation ends
// - status write clears the latch when it ends
// - status write loads protect, quad, lock
// - protect pattern selects write-protected blocks
// - quad function follows the quad bit
// - lock bit set means status protected
// - busy, latch volatile; other bits retained
// - lock set and pin low: ignore status writes
// - two volatile opcodes need no write-enable; the core does not decode C0h or 17h at all
// - continuous status read repeats the byte
`timescale 1ns/1ns
`default_nettype none
module fsw_status_core #(
   parameter int OP_CYCLES = fsw_pkg::OP_CYCLES_DEF,
   parameter logic TOP_AREA = 1'b1,
   parameter logic [7:0] WRITE_DISABLE_INSTR_OP = 8'h04,
   parameter logic [7:0] RDSR_OP = 8'h05,
   parameter logic [7:0] SWRESET_OP = 8'h99
) (
   // core clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // serial link pins
   input wire logic sck_i,
   input wire logic ce_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   // protection pins
   input wire logic wp_n_i,
   input wire logic hw_reset_n_i,
   // array side
   input wire logic [fsw_pkg::BLK_W-1:0] block_index_i,
   output logic block_protected_o,
   output logic quad_enable_o,
   output logic status_locked_o,
   output logic busy_o,
   output logic [7:0] status_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      fsw_pkg::fsw_state_type st;
      logic write_enable_latch;
      logic [3:0] bp;
      logic qe;
      logic status_write_disable;
      logic op_write_status_instr;
      logic op_pe;
      logic [7:0] pend;
      logic [fsw_pkg::TIMER_W-1:0] timer;
      logic ce_prev;
      logic frm_seen;
      logic blk_prot;
   } fsw_core_type;

   fsw_core_type r_reg;
   fsw_core_type r_next;
   fsw_pkg::fsw_cmd_type cmd;
   logic [3:0] pins_s;
   logic ce_s;
   logic frm_s;
   logic wp_n_s;
   logic hwr_n_s;
   logic [7:0] status_val;

   localparam logic [fsw_pkg::TIMER_W-1:0] OP_LOAD =
      fsw_pkg::TIMER_W'(OP_CYCLES);

   // ---------------------------------------------------------------
   // opcode classes
   // ---------------------------------------------------------------
   // C0h and 17h are volatile and absent from the table
   function automatic logic is_gated(input logic [7:0] op);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < fsw_pkg::N_GATED; i++) begin
         if (fsw_pkg::GATED_OPS[i] == op) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic is_prog_erase(input logic [7:0] op);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < fsw_pkg::N_PE; i++) begin
         if (fsw_pkg::GATED_OPS[i] == op) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // ---------------------------------------------------------------
   // link and pin crossings
   // ---------------------------------------------------------------
   fsw_link #(.RDSR_OP(RDSR_OP)) u_link (
      .sck_i(sck_i),
      .ce_n_i(ce_n_i),
      .si_i(si_i),
      .so_o(so_o),
      .so_oe_o(so_oe_o),
      .reset_n_i(reset_n_i),
      .status_i(status_val),
      .cmd_o(cmd)
   );

   // cmd words are stable once ce_n is high, so only levels cross
   fsw_sync2 #(.W(4)) u_pin_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .d_i({ce_n_i, cmd.frame_tgl, wp_n_i, hw_reset_n_i}),
      .q_o(pins_s)
   );

   assign ce_s = pins_s[3];
   assign frm_s = pins_s[2];
   assign wp_n_s = pins_s[1];
   assign hwr_n_s = pins_s[0];

   // ---------------------------------------------------------------
   // command execution
   // ---------------------------------------------------------------
   always_comb begin
      logic exec;
      logic start;
      logic lock;
      logic [7:0] op;
      logic [9:0] cnt;
      logic [9:0] blk;
      exec = 1'b0;
      start = 1'b0;
      lock = 1'b0;
      op = cmd.opcode;
      cnt = 10'h000;
      blk = 10'h000;
      r_next = r_reg;
      r_next.ce_prev = ce_s;

      // operation timer; ends clear busy and latch
      if (r_reg.st == fsw_pkg::FSW_BUSY) begin
         if (r_reg.timer <= 16'h0001) begin
            r_next.st = fsw_pkg::FSW_IDLE;
            r_next.timer = '0;
            r_next.write_enable_latch = 1'b0;
            if (r_reg.op_write_status_instr) begin
               r_next.bp = r_reg.pend[fsw_pkg::BP_LSB +: fsw_pkg::BP_W];
               r_next.qe = r_reg.pend[fsw_pkg::QE_BIT];
               r_next.status_write_disable = r_reg.pend[fsw_pkg::STATUS_WRITE_DISABLE_BIT];
            end
         end else begin
            r_next.timer = r_reg.timer - 16'h0001;
         end
      end

      // a frame counts once, on ce_n rising, if its opcode arrived
      if (ce_s && !r_reg.ce_prev) begin
         r_next.frm_seen = frm_s;
         exec = (frm_s != r_reg.frm_seen) && cmd.got_op;
      end

      // lock bit with write-protect pin low freezes status
      lock = r_reg.status_write_disable && !wp_n_s;

      if (exec) begin
         if (op == SWRESET_OP) begin
            // abort; volatile bits only, nonvolatile ones kept
            r_next.st = fsw_pkg::FSW_IDLE;
            r_next.write_enable_latch = 1'b0;
            r_next.timer = '0;
         end else if (r_reg.st == fsw_pkg::FSW_BUSY) begin
            // everything but suspend during program or erase is dropped while busy
            if (op == fsw_pkg::OP_SUSPEND && r_reg.op_pe) begin
               r_next.st = fsw_pkg::FSW_SUSP;
            end
         end else if (r_reg.st == fsw_pkg::FSW_SUSP) begin
            // no new array operation while one is parked
            if (op == fsw_pkg::OP_RESUME) begin
               r_next.st = fsw_pkg::FSW_BUSY;
            end else if (op == fsw_pkg::OP_WRITE_ENABLE_INSTR) begin
               r_next.write_enable_latch = 1'b1;
            end else if (op == WRITE_DISABLE_INSTR_OP) begin
               r_next.write_enable_latch = 1'b0;
            end
         end else if (op == fsw_pkg::OP_WRITE_ENABLE_INSTR) begin
            r_next.write_enable_latch = 1'b1;
         end else if (op == WRITE_DISABLE_INSTR_OP) begin
            r_next.write_enable_latch = 1'b0;
         end else if (is_gated(op) && r_reg.write_enable_latch) begin
            // latch set: gated operations go ahead
            if (op == fsw_pkg::OP_WRITE_STATUS_INSTR) begin
               start = cmd.got_data && !lock;
            end else if (op == fsw_pkg::OP_CER_A ||
                         op == fsw_pkg::OP_CER_B) begin
               // chip erase only with no block protected
               start = (r_reg.bp == 4'h0);
            end else begin
               start = 1'b1;
            end
         end
         // gated opcode with latch clear falls through untouched
      end

      if (start) begin
         r_next.st = fsw_pkg::FSW_BUSY;
         r_next.timer = OP_LOAD;
         r_next.op_write_status_instr = (op == fsw_pkg::OP_WRITE_STATUS_INSTR);
         r_next.op_pe = is_prog_erase(op);
         r_next.pend = cmd.data;
         // the latch stays as is until the operation ends
      end

      // hardware reset pin aborts like the software reset
      if (!hwr_n_s) begin
         r_next.st = fsw_pkg::FSW_IDLE;
         r_next.write_enable_latch = 1'b0;
         r_next.timer = '0;
      end

      // protected block span from the pattern, top or bottom
      cnt = fsw_pkg::PROT_COUNT[r_reg.bp];
      blk = {1'b0, block_index_i};
      if (TOP_AREA) begin
         r_next.blk_prot = (cnt != 10'h000) &&
                           (blk >= fsw_pkg::NUM_BLOCKS - cnt);
      end else begin
         r_next.blk_prot = blk < cnt;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // power-on reset also loads the retained bits with factory values
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         r_reg <= '0;
         r_reg.st <= fsw_pkg::FSW_IDLE;
         r_reg.bp <= fsw_pkg::NV_BP_RESET;
         r_reg.qe <= fsw_pkg::NV_QE_RESET;
         r_reg.status_write_disable <= fsw_pkg::NV_STATUS_WRITE_DISABLE_RESET;
         r_reg.ce_prev <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      status_val = fsw_pkg::STAT_RESET;
      status_val[fsw_pkg::BUSY_BIT] = (r_reg.st == fsw_pkg::FSW_BUSY);
      status_val[fsw_pkg::WEL_BIT] = r_reg.write_enable_latch;
      status_val[fsw_pkg::BP_LSB +: fsw_pkg::BP_W] = r_reg.bp;
      status_val[fsw_pkg::QE_BIT] = r_reg.qe;
      status_val[fsw_pkg::STATUS_WRITE_DISABLE_BIT] = r_reg.status_write_disable;
   end

   assign status_o = status_val;
   assign busy_o = status_val[fsw_pkg::BUSY_BIT];
   assign quad_enable_o = r_reg.qe;
   assign status_locked_o = r_reg.status_write_disable && !wp_n_s;
   assign block_protected_o = r_reg.blk_prot;

endmodule
`default_nettype wire

// ### rtl/fsw_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module fsw_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // level in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } fsw_sync_type;

   fsw_sync_type r_reg;
   fsw_sync_type r_next;

   always_comb begin
      r_next.meta = d_i;
      r_next.sync = r_reg.meta;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign q_o = r_reg.sync;

endmodule
`default_nettype wire

// ### sim/flash_status_write_enable_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flash_status_write_enable_tb_top;
   localparam int OPC = 400;
   localparam logic [7:0] WRITE_DISABLE_INSTR = 8'h04;
   localparam logic [7:0] RDSR = 8'h05;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wp_n_i = 1'b1;
   logic hw_reset_n_i = 1'b1;
   logic [8:0] block_index_i = 9'h000;
   logic sck, ce_n, si, so, so_oe, prot, quad, lock, busy;
   logic [7:0] status, rd, d, r;
   // retained bits as last written; they only load at operation end
   logic [7:0] nv = 8'h00;
   logic [7:0] lfsr = 8'h16;
   logic [9:0] b;
   int fail_count = 0;
   int checks = 0;

   always #10 clk_i = ~clk_i;

   fsw_host_model host_u (
      .sck_o(sck), .ce_n_o(ce_n), .si_o(si), .so_i(so), .so_oe_i(so_oe)
   );
   fsw_status_core #(
      .OP_CYCLES(OPC), .WRITE_DISABLE_INSTR_OP(WRITE_DISABLE_INSTR), .RDSR_OP(RDSR), .SWRESET_OP(8'h99)
   ) dut_u (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .sck_i(sck), .ce_n_i(ce_n),
      .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n_i),
      .hw_reset_n_i(hw_reset_n_i), .block_index_i(block_index_i),
      .block_protected_o(prot), .quad_enable_o(quad),
      .status_locked_o(lock), .busy_o(busy), .status_o(status)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   // top-area table: the last blocks are the protected ones
   function automatic logic prot_exp(input logic [3:0] bp,
         input logic [8:0] idx);
      return {1'b0, idx} >= fsw_pkg::NUM_BLOCKS - fsw_pkg::PROT_COUNT[bp];
   endfunction
   task automatic check(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] dat,
         input int nb);
      host_u.frame(op, dat, nb, rd);
      repeat (8) @(negedge clk_i);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 1000 && busy !== 1'b0; k++) begin
         @(negedge clk_i);
      end
      check("idle", {7'h00, busy}, 8'h00);
   endtask
   task automatic results();
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(negedge clk_i);
      check("reset", status, 8'h00);
      for (int i = 0; i < fsw_pkg::N_GATED; i++) begin
         cmd(fsw_pkg::GATED_OPS[i], rnd(), 2);
         check("gated", status, 8'h00);
      end
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      check("wel set", status, 8'h02);
      cmd(WRITE_DISABLE_INSTR, 8'h00, 1);
      check("wel clear", status, 8'h00);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         d = (i == 0) ? 8'h3D : (i == 1) ? 8'h41 : {1'b0, r[6:2], 2'b01};
         cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
         cmd(fsw_pkg::OP_WRITE_STATUS_INSTR, d, 2);
         check("busy", status, {nv[7:2], 2'b11});
         cmd(WRITE_DISABLE_INSTR, 8'h00, 1);
         cmd(fsw_pkg::OP_SUSPEND, 8'h00, 1);
         host_u.frame(RDSR, 8'h00, 3, rd);
         check("read", rd, {nv[7:2], 2'b11});
         wait_idle();
         nv = d;
         check("done", status, {d[7:2], 2'b00});
         check("quad", {7'h00, quad}, {7'h00, d[6]});
         b = 10'h200 - fsw_pkg::PROT_COUNT[d[5:2]];
         for (int j = 0; j < 4; j++) begin
            r = rnd();
            @(posedge clk_i);
            block_index_i <= (j == 0) ? 9'h1FF : (j == 1) ? b[8:0] :
               (j == 2) ? b[8:0] - 9'h001 : {r, r[0]};
            repeat (2) @(negedge clk_i);
            check("protect", {7'h00, prot},
               {7'h00, prot_exp(d[5:2], block_index_i)});
         end
      end
      @(posedge clk_i);
      wp_n_i <= 1'b0;
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      cmd(fsw_pkg::OP_WRITE_STATUS_INSTR, 8'h94, 2);
      wait_idle();
      check("locked", {7'h00, lock}, 8'h01);
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      cmd(fsw_pkg::OP_WRITE_STATUS_INSTR, 8'h00, 2);
      check("ignored", status, 8'h96);
      cmd(8'h02, rnd(), 2);
      check("program", status, 8'h97);
      cmd(fsw_pkg::OP_SUSPEND, 8'h00, 1);
      check("suspend", status, 8'h96);
      cmd(fsw_pkg::OP_RESUME, 8'h00, 1);
      check("resume", status, 8'h97);
      @(posedge clk_i);
      hw_reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      hw_reset_n_i <= 1'b1;
      repeat (6) @(negedge clk_i);
      check("abort", status, 8'h94);
      @(posedge clk_i);
      wp_n_i <= 1'b1;
      repeat (6) @(negedge clk_i);
      check("unlocked", {7'h00, lock}, 8'h00);
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      cmd(fsw_pkg::OP_WRITE_STATUS_INSTR, 8'h00, 2);
      wait_idle();
      check("rewrite", status, 8'h00);
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      cmd(8'hD8, rnd(), 2);
      check("erase", status, 8'h03);
      wait_idle();
      check("erased", status, 8'h00);
      cmd(fsw_pkg::OP_WRITE_ENABLE_INSTR, 8'h00, 1);
      cmd(8'h7E, rnd(), 2);
      check("gang", status, 8'h03);
      wait_idle();
      check("ganged", status, 8'h00);
      results();
   end

   initial begin
      #600000;
      fail_count++;
      results();
   end
endmodule
`default_nettype wire

// ### sim/fsw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsw_host_model (
   // link pins
   output logic sck_o,
   output logic ce_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   initial begin
      sck_o = 1'b0;
      ce_n_o = 1'b1;
      si_o = 1'b0;
   end
   // ------------------------------------------------------------
   // mode 0 frame; clock only inside, data flips once released
   // ------------------------------------------------------------
   task automatic frame(input logic [7:0] op, input logic [7:0] dat,
         input int nb, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {op, dat};
      rd = 8'h00;
      #7 ce_n_o = 1'b0;
      for (int i = 0; i < nb * 8; i++) begin
         si_o = (i < 16) ? sh[15 - i] : ~si_o;
         #62 sck_o = 1'b1;
         rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
         #63 sck_o = 1'b0;
      end
      #40 ce_n_o = 1'b1;
      si_o = ~si_o;
   endtask
endmodule
`default_nettype wire

// ### sim/fsw_status_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fsw_status_core_assertions #(
   parameter int OP_CYCLES = 64
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // pins
   input wire logic ce_n_i,
   input wire logic wp_n_i,
   input wire logic so_oe_o,
   // status outputs
   input wire logic block_protected_o,
   input wire logic quad_enable_o,
   input wire logic status_locked_o,
   input wire logic busy_o,
   input wire logic [7:0] status_o
);
   // ------------------------------------------------------------
   // busy run length
   // ------------------------------------------------------------
   logic [15:0] run_reg;
   logic [15:0] run_next;
   always_comb begin
      run_next = (reset_n_i && busy_o) ? run_reg + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_i) begin
      run_reg <= run_next;
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_op_start;
      $rose(busy_o);
   endsequence
   sequence s_bp_all;
      (status_o[5:2] == 4'hF) [*2];
   endsequence
   sequence s_bp_none;
      (status_o[5:2] == 4'h0) [*2];
   endsequence

   chk_reset_clear: assert property (disable iff (1'b0)
      !reset_n_i |=> status_o == 8'h00 && !busy_o)
      else $error("status not clear after reset");
   chk_busy_mirror: assert property (status_o[0] == busy_o)
      else $error("busy bit differs from busy output");
   chk_start_wel: assert property (s_op_start |-> status_o[1])
      else $error("operation started without latch");
   chk_busy_bound: assert property (busy_o |-> run_reg < OP_CYCLES)
      else $error("busy lasted too long");
   chk_wel_end: assert property (
      $fell(busy_o) && run_reg == OP_CYCLES |-> !status_o[1])
      else $error("latch kept after operation end");
   chk_busy_freeze: assert property (
      busy_o && $past(busy_o) |-> $stable(status_o[7:1]))
      else $error("status changed while busy");
   chk_lock_frozen: assert property (
      status_locked_o && $past(status_locked_o) |-> $stable(status_o[7:2]))
      else $error("locked status changed");
   chk_pin_unlock: assert property (wp_n_i [*4] |-> !status_locked_o)
      else $error("locked with pin high");
   chk_quad_follow: assert property (
      $stable(status_o[6]) [*3] |-> quad_enable_o == status_o[6])
      else $error("quad output differs from bit");
   chk_prot_all: assert property (s_bp_all |-> block_protected_o)
      else $error("block not protected with all bits set");
   chk_prot_none: assert property (s_bp_none |-> !block_protected_o)
      else $error("block protected with no bits set");
   chk_out_framed: assert property (so_oe_o |-> !ce_n_i)
      else $error("output driven outside frame");
endmodule

bind fsw_status_core fsw_status_core_assertions #(
   .OP_CYCLES(OP_CYCLES)
) chk_u (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_n_i(ce_n_i),
   .wp_n_i(wp_n_i), .so_oe_o(so_oe_o),
   .block_protected_o(block_protected_o), .quad_enable_o(quad_enable_o),
   .status_locked_o(status_locked_o), .busy_o(busy_o), .status_o(status_o)
);
`default_nettype wire
